// ==== verilog/pos_pkg.sv ====
// constants for the on/off control and status register block
package pos_pkg;

	// ****************************************
	// command codes
	// ****************************************
	localparam logic [7:0] CMD_UNIT_ON_OFF = 8'h01;
	localparam logic [7:0] CMD_ENABLE_CFG = 8'h02;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
	localparam logic [7:0] CMD_VOUT_SETPOINT = 8'h21;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7A;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7B;
	localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
	localparam logic [7:0] CMD_STATUS_TEMP = 8'h7D;
	localparam logic [7:0] CMD_STATUS_COMM = 8'h7E;
	localparam logic [7:0] CMD_STATUS_VENDOR = 8'h80;

	// ****************************************
	// widths, fields and reset values
	// ****************************************
	localparam int DATA_W = 16;
	localparam logic [1:0] OP_SOFT_OFF = 2'b01;
	localparam logic [1:0] OP_ON = 2'b10;
	localparam logic [1:0] OP_MARGIN_OFF = 2'b00;
	localparam int CFG_W = 4;
	localparam int CFG_POLARITY = 1;
	localparam int CFG_PIN_EN = 2;
	localparam int CFG_CMD_EN = 3;
	localparam logic [7:0] OP_RESET = 8'h40;
	localparam logic [3:0] CFG_RESET = 4'h6;
	localparam logic [15:0] VSET_RESET = 16'h0000;
	localparam logic [2:0] VOUT_LINEAR_MODE = 3'b000;
	localparam logic [4:0] VOUT_EXPONENT = 5'h14;

	// ****************************************
	// sticky flag indices
	// ****************************************
	localparam int F_VOUT_UVF = 0;
	localparam int F_VOUT_UVW = 1;
	localparam int F_VOUT_OVW = 2;
	localparam int F_VOUT_OVF = 3;
	localparam int F_IOUT_OCW = 4;
	localparam int F_IOUT_OCF = 5;
	localparam int F_VIN_UVF = 6;
	localparam int F_VIN_UVW = 7;
	localparam int F_VIN_OVW = 8;
	localparam int F_VIN_OVF = 9;
	localparam int F_TEMP_OVW = 10;
	localparam int F_TEMP_OVF = 11;
	localparam int F_VEND_OVW = 12;
	localparam int F_VEND_OVF = 13;
	localparam int F_BUS_FMT = 14;
	localparam int F_PKT_CHK = 15;
	localparam int F_BAD_CMD = 16;
	localparam int FLAG_W = 17;

endpackage : pos_pkg

// ==== verilog/pos_sync.sv ====
// two-stage synchroniser for one asynchronous level
`timescale 1ns/10ps
module pos_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// asynchronous level in, synchronised level out
	input wire logic i_async,
	output logic o_sync
);
	import pos_pkg::*;

	logic stage1;

	// stage1 is read by the second flop only
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stage1 <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end

endmodule : pos_sync

// ==== verilog/pos_sticky.sv ====
// bank of sticky status flags, set wins over clear
`timescale 1ns/10ps
module pos_sticky #(
	parameter int WIDTH = 17
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// set levels and clear strobe
	input wire logic [WIDTH-1:0] i_set,
	input wire logic i_clear,
	// latched flags
	output logic [WIDTH-1:0] o_flags
);
	import pos_pkg::*;

	logic [WIDTH-1:0] next_flags;

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_flag
			// a condition still present on clear sets the bit again at once
			always_comb begin
				next_flags[gi] = (o_flags[gi] & ~i_clear) | i_set[gi];
			end
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_flags <= '0;
		end else begin
			o_flags <= next_flags;
		end
	end

endmodule : pos_sticky

// ==== verilog/pos_regs.sv ====
// on/off control, output voltage setpoint and status registers
//
// Functional notes
// - top bits 01 soft off, 10 on, 00/11 refused
// - mode held until new command or pin change
// - config bit 0 ignored, off always sequenced
// - config bit 1 selects control pin polarity
// - config bit 2 gates on control pin
// - config bit 3 gates on command field
// - both enabled: on only when both on
// - fault clear resets flags, releases alert
// - fault clear leaves operating state untouched
// - persisting condition sets its bit again
// - format byte: exponent low, 000 on top
// - setpoint is 16-bit mantissa, host scales
// - summary bits 1 to 5 per source
// - bit 0 other faults, bit 7 zero
// - bit 6 set while output unpowered
// - word low byte mirrors byte, 8-10 zero
// - word bit 11 while power good negated
// - word bits 12-15 vendor/input/current/voltage
// - voltage status bits 7:4, 3:0 zero
// - current warning bit 5, fault bit 7
// - comm bits 1, 5, 7 feed summary
`timescale 1ns/10ps
module pos_regs (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// command port from the bus transport
	input wire logic i_cmd_valid,
	input wire logic i_cmd_read,
	input wire logic [7:0] i_cmd_code,
	input wire logic [pos_pkg::DATA_W-1:0] i_cmd_wdata,
	output logic o_rd_valid,
	output logic [pos_pkg::DATA_W-1:0] o_rd_data,
	// transport error strobes
	input wire logic i_bus_timeout_format,
	input wire logic i_packet_check_error,
	// external control pin, asynchronous
	input wire logic i_control_pin,
	// power stage state
	input wire logic i_output_active,
	input wire logic i_power_good,
	// output voltage conditions
	input wire logic i_output_undervolt_fault,
	input wire logic i_output_undervolt_warning,
	input wire logic i_output_overvolt_warning,
	input wire logic i_output_overvolt_fault,
	// output current conditions
	input wire logic i_overcurrent_warning,
	input wire logic i_overcurrent_fault,
	// input voltage conditions
	input wire logic i_input_undervolt_fault,
	input wire logic i_input_undervolt_warning,
	input wire logic i_input_overvolt_warning,
	input wire logic i_input_overvolt_fault,
	// temperature conditions
	input wire logic i_ext_overtemp_warning,
	input wire logic i_ext_overtemp_fault,
	input wire logic i_int_overtemp_warning,
	input wire logic i_int_overtemp_fault,
	// to the sequencer and the alert pin driver
	output logic o_unit_enable,
	output logic [pos_pkg::DATA_W-1:0] o_vout_setpoint,
	output logic o_alert
);
	import pos_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0] unit_on_off_command;
	logic [CFG_W-1:0] enable_source_config;
	logic [7:0] next_unit_on_off_command;
	logic [CFG_W-1:0] next_enable_source_config;
	logic [DATA_W-1:0] next_vout_setpoint;
	logic next_rd_valid;
	logic [DATA_W-1:0] next_rd_data;
	logic next_unit_enable;
	logic next_alert;
	logic clear_req;
	logic bad_cmd;
	logic pin_level;
	logic pin_on;
	logic cmd_on;
	logic [FLAG_W-1:0] flag_set;
	logic [FLAG_W-1:0] flags;
	logic [7:0] vout_format_exponent;
	logic [7:0] summary_status_byte;
	logic [15:0] summary_status_word;
	logic [7:0] output_voltage_status;
	logic [7:0] output_current_status;
	logic [7:0] input_status;
	logic [7:0] temp_status;
	logic [7:0] comm_status;
	logic [7:0] vendor_status;
	logic other_fault_flag;
	logic comm_fault_flag;
	logic temp_flag;
	logic input_undervolt_flag;
	logic overcurrent_summary_flag;
	logic overvolt_summary_flag;
	logic vendor_event_flag;
	logic input_event_flag;
	logic output_current_power_flag;
	logic output_voltage_flag;

	// ****************************************
	// control pin synchroniser
	// ****************************************
	pos_sync u_pin_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async(i_control_pin),
		.o_sync(pin_level)
	);

	// ****************************************
	// sticky status flags
	// ****************************************
	always_comb begin
		flag_set = '0;
		flag_set[F_VOUT_UVF] = i_output_undervolt_fault;
		flag_set[F_VOUT_UVW] = i_output_undervolt_warning;
		flag_set[F_VOUT_OVW] = i_output_overvolt_warning;
		flag_set[F_VOUT_OVF] = i_output_overvolt_fault;
		flag_set[F_IOUT_OCW] = i_overcurrent_warning;
		flag_set[F_IOUT_OCF] = i_overcurrent_fault;
		flag_set[F_VIN_UVF] = i_input_undervolt_fault;
		flag_set[F_VIN_UVW] = i_input_undervolt_warning;
		flag_set[F_VIN_OVW] = i_input_overvolt_warning;
		flag_set[F_VIN_OVF] = i_input_overvolt_fault;
		flag_set[F_TEMP_OVW] = i_ext_overtemp_warning;
		flag_set[F_TEMP_OVF] = i_ext_overtemp_fault;
		flag_set[F_VEND_OVW] = i_int_overtemp_warning;
		flag_set[F_VEND_OVF] = i_int_overtemp_fault;
		flag_set[F_BUS_FMT] = i_bus_timeout_format;
		flag_set[F_PKT_CHK] = i_packet_check_error;
		flag_set[F_BAD_CMD] = bad_cmd;
	end

	pos_sticky #(
		.WIDTH(FLAG_W)
	) u_flags (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_set(flag_set),
		.i_clear(clear_req),
		.o_flags(flags)
	);

	// ****************************************
	// status register assembly
	// ****************************************
	always_comb begin
		output_voltage_status = {flags[F_VOUT_OVF], flags[F_VOUT_OVW],
			flags[F_VOUT_UVW], flags[F_VOUT_UVF], 4'h0};
		output_current_status = {flags[F_IOUT_OCF], 1'b0,
			flags[F_IOUT_OCW], 5'h00};
		input_status = {flags[F_VIN_OVF], flags[F_VIN_OVW],
			flags[F_VIN_UVW], flags[F_VIN_UVF], 4'h0};
		temp_status = {flags[F_TEMP_OVF], flags[F_TEMP_OVW], 6'h00};
		vendor_status = {flags[F_VEND_OVF], flags[F_VEND_OVW], 6'h00};
		comm_status = {flags[F_BAD_CMD], 1'b0, flags[F_PKT_CHK], 3'h0,
			flags[F_BUS_FMT], 1'b0};
	end

	always_comb begin
		comm_fault_flag = |comm_status;
		temp_flag = |temp_status;
		input_undervolt_flag = flags[F_VIN_UVF];
		overcurrent_summary_flag = flags[F_IOUT_OCF];
		overvolt_summary_flag = flags[F_VOUT_OVF];
		// faults with no summary bit of their own
		other_fault_flag = flags[F_VOUT_UVF] | flags[F_VIN_OVF] | flags[F_VEND_OVF];
		vendor_event_flag = |vendor_status;
		input_event_flag = |input_status;
		output_current_power_flag = |output_current_status;
		output_voltage_flag = |output_voltage_status;
	end

	always_comb begin
		summary_status_byte = {1'b0,
			~i_output_active,
			overvolt_summary_flag,
			overcurrent_summary_flag,
			input_undervolt_flag,
			temp_flag,
			comm_fault_flag,
			other_fault_flag};
		// bits 10:8 report nothing in this unit
		summary_status_word = {output_voltage_flag,
			output_current_power_flag,
			input_event_flag,
			vendor_event_flag,
			~i_power_good,
			3'h0,
			summary_status_byte};
		vout_format_exponent = {VOUT_LINEAR_MODE, VOUT_EXPONENT};
	end

	// ****************************************
	// command decode and register writes
	// ****************************************
	always_comb begin
		next_unit_on_off_command = unit_on_off_command;
		next_enable_source_config = enable_source_config;
		next_vout_setpoint = o_vout_setpoint;
		next_rd_valid = 1'b0;
		next_rd_data = o_rd_data;
		clear_req = 1'b0;
		bad_cmd = 1'b0;
		if (i_cmd_valid && i_cmd_read) begin
			next_rd_valid = 1'b1;
			// spare and unsupported bits read as zero
			next_rd_data = '0;
			unique case (i_cmd_code)
				CMD_UNIT_ON_OFF: begin
					next_rd_data = {8'h00, unit_on_off_command};
				end
				CMD_ENABLE_CFG: begin
					next_rd_data = {12'h000, enable_source_config};
				end
				CMD_VOUT_FORMAT: begin
					next_rd_data = {8'h00, vout_format_exponent};
				end
				CMD_VOUT_SETPOINT: begin
					next_rd_data = o_vout_setpoint;
				end
				CMD_STATUS_BYTE: begin
					next_rd_data = {8'h00, summary_status_byte};
				end
				CMD_STATUS_WORD: begin
					next_rd_data = summary_status_word;
				end
				CMD_OUTPUT_VOLTAGE_STATUS: begin
					next_rd_data = {8'h00, output_voltage_status};
				end
				CMD_OUTPUT_CURRENT_STATUS: begin
					next_rd_data = {8'h00, output_current_status};
				end
				CMD_STATUS_INPUT: begin
					next_rd_data = {8'h00, input_status};
				end
				CMD_STATUS_TEMP: begin
					next_rd_data = {8'h00, temp_status};
				end
				CMD_STATUS_COMM: begin
					next_rd_data = {8'h00, comm_status};
				end
				CMD_STATUS_VENDOR: begin
					next_rd_data = {8'h00, vendor_status};
				end
				default: begin
					// write-only or unknown code answers zero
					bad_cmd = 1'b1;
				end
			endcase
		end else if (i_cmd_valid) begin
			unique case (i_cmd_code)
				CMD_UNIT_ON_OFF: begin
					// only the two documented modes are taken
					if (i_cmd_wdata[7:6] == OP_SOFT_OFF) begin
						next_unit_on_off_command = i_cmd_wdata[7:0];
					end else if (i_cmd_wdata[7:6] == OP_ON && i_cmd_wdata[5:4] == OP_MARGIN_OFF) begin
						next_unit_on_off_command = i_cmd_wdata[7:0];
					end else begin
						bad_cmd = 1'b1;
					end
				end
				CMD_ENABLE_CFG: begin
					// bit 0 is stored for read-back only
					next_enable_source_config = i_cmd_wdata[CFG_W-1:0];
				end
				CMD_CLEAR_FAULTS: begin
					// flags only; control state is left as it is
					clear_req = 1'b1;
				end
				CMD_VOUT_SETPOINT: begin
					next_vout_setpoint = i_cmd_wdata;
				end
				default: begin
					// read-only or unknown code
					bad_cmd = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			unit_on_off_command <= OP_RESET;
			enable_source_config <= CFG_RESET;
			o_vout_setpoint <= VSET_RESET;
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
		end else begin
			unit_on_off_command <= next_unit_on_off_command;
			enable_source_config <= next_enable_source_config;
			o_vout_setpoint <= next_vout_setpoint;
			o_rd_valid <= next_rd_valid;
			o_rd_data <= next_rd_data;
		end
	end

	// ****************************************
	// on/off decision
	// ****************************************
	// enable drops straight away; the sequencer always applies the
	// programmed delay and fall time, so no fast-off path exists
	always_comb begin
		// pin level is two edges old, so enable trails the pin by three
		pin_on = (pin_level == enable_source_config[CFG_POLARITY]);
		cmd_on = (unit_on_off_command[7:6] == OP_ON);
		next_unit_enable = (~enable_source_config[CFG_PIN_EN] | pin_on)
			& (~enable_source_config[CFG_CMD_EN] | cmd_on);
	end

	// ****************************************
	// alert
	// ****************************************
	// released by a clear unless a condition is still present
	always_comb begin
		next_alert = |flags;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_unit_enable <= 1'b0;
			o_alert <= 1'b0;
		end else begin
			o_unit_enable <= next_unit_enable;
			o_alert <= next_alert;
		end
	end

endmodule : pos_regs

// ==== sim/pos_pin_model.sv ====
// external driver of the control pin, on its own slow clock
`timescale 1ns/10ps
module pos_pin_model (
	// wanted level
	input wire logic i_level,
	// pin
	output logic o_pin
);
	logic lclk = 1'b0;
	initial o_pin = 1'b0;
	always #160 lclk = ~lclk;
	// pin moves only on its own edges, which always land on falling edges of the block clock
	always @(posedge lclk) o_pin <= i_level;
endmodule : pos_pin_model

// ==== sim/pos_regs_props.sv ====
// concurrent checks on the register block ports
`timescale 1ns/10ps
module pos_regs_chk import pos_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// command port
	input wire logic i_cmd_valid,
	input wire logic i_cmd_read,
	input wire logic [7:0] i_cmd_code,
	input wire logic [pos_pkg::DATA_W-1:0] i_cmd_wdata,
	input wire logic o_rd_valid,
	input wire logic [pos_pkg::DATA_W-1:0] o_rd_data,
	// state and outputs
	input wire logic i_output_active,
	input wire logic i_power_good,
	input wire logic i_overcurrent_fault,
	input wire logic [pos_pkg::DATA_W-1:0] o_vout_setpoint,
	input wire logic o_alert
);
	logic rd;
	assign rd = i_cmd_valid & i_cmd_read;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	chk_read_answer: assert property (rd |=> o_rd_valid) else $error("read not answered");
	chk_no_spurious: assert property (!rd |=> !o_rd_valid) else $error("answer without read");
	chk_setpoint_write: assert property (i_cmd_valid && !i_cmd_read && i_cmd_code == CMD_VOUT_SETPOINT
		|=> o_vout_setpoint == $past(i_cmd_wdata)) else $error("setpoint not taken");
	chk_format_read: assert property (rd && i_cmd_code == CMD_VOUT_FORMAT
		|=> o_rd_data == {8'h00, 3'h0, VOUT_EXPONENT}) else $error("format byte wrong");
	chk_byte_off_bit: assert property (rd && i_cmd_code == CMD_STATUS_BYTE
		|=> o_rd_data[6] == !$past(i_output_active) && o_rd_data[15:7] == 9'h000) else $error("byte off bit");
	chk_word_pg_bit: assert property (rd && i_cmd_code == CMD_STATUS_WORD
		|=> o_rd_data[11] == !$past(i_power_good) && o_rd_data[10:8] == 3'h0) else $error("word pg bit");
	chk_vout_unused: assert property (rd && i_cmd_code == CMD_OUTPUT_VOLTAGE_STATUS
		|=> o_rd_data[3:0] == 4'h0 && o_rd_data[15:8] == 8'h00) else $error("vout spare bits");
	chk_iout_unused: assert property (rd && i_cmd_code == CMD_OUTPUT_CURRENT_STATUS
		|=> {o_rd_data[15:8], o_rd_data[6], o_rd_data[4:0]} == 14'h0000) else $error("iout spare bits");
	chk_fault_alert: assert property (i_overcurrent_fault |-> ##[1:3] o_alert) else $error("alert missing");
endmodule : pos_regs_chk
bind pos_regs pos_regs_chk chk (.i_clk(i_clk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid),
	.i_cmd_read(i_cmd_read), .i_cmd_code(i_cmd_code), .i_cmd_wdata(i_cmd_wdata), .o_rd_valid(o_rd_valid),
	.o_rd_data(o_rd_data), .i_output_active(i_output_active), .i_power_good(i_power_good),
	.i_overcurrent_fault(i_overcurrent_fault), .o_vout_setpoint(o_vout_setpoint), .o_alert(o_alert));

// ==== sim/testbench.sv ====
// self-checking bench for the on/off and status register block
`timescale 1ns/10ps
module testbench;
	import pos_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_cmd_valid = 1'b0;
	logic i_cmd_read = 1'b0;
	logic [7:0] i_cmd_code = 8'h00;
	logic [DATA_W-1:0] i_cmd_wdata = 16'h0000;
	logic [15:0] cond = 16'h0000;
	logic act = 1'b1;
	logic pg = 1'b1;
	logic pin_want = 1'b0;
	logic pin;
	logic o_rd_valid;
	logic o_unit_enable;
	logic o_alert;
	logic [DATA_W-1:0] o_rd_data;
	logic [DATA_W-1:0] o_vout_setpoint;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	// {cfg, command on, pin, enable expected}, first row in the top bits
	localparam logic [83:0] EN_TAB = {7'h01, 7'h33, 7'h30, 7'h11, 7'h21, 7'h22,
		7'h45, 7'h40, 7'h4D, 7'h77, 7'h74, 7'h72};
	always #20 i_clk = ~i_clk;
	pos_pin_model pin_drv (.i_level(pin_want), .o_pin(pin));
	pos_regs dut (.i_clk(i_clk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid), .i_cmd_read(i_cmd_read),
		.i_cmd_code(i_cmd_code), .i_cmd_wdata(i_cmd_wdata), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
		.i_bus_timeout_format(cond[14]), .i_packet_check_error(cond[15]), .i_control_pin(pin),
		.i_output_active(act), .i_power_good(pg), .i_output_undervolt_fault(cond[0]),
		.i_output_undervolt_warning(cond[1]), .i_output_overvolt_warning(cond[2]),
		.i_output_overvolt_fault(cond[3]), .i_overcurrent_warning(cond[4]), .i_overcurrent_fault(cond[5]),
		.i_input_undervolt_fault(cond[6]), .i_input_undervolt_warning(cond[7]),
		.i_input_overvolt_warning(cond[8]), .i_input_overvolt_fault(cond[9]),
		.i_ext_overtemp_warning(cond[10]), .i_ext_overtemp_fault(cond[11]),
		.i_int_overtemp_warning(cond[12]), .i_int_overtemp_fault(cond[13]),
		.o_unit_enable(o_unit_enable), .o_vout_setpoint(o_vout_setpoint), .o_alert(o_alert));
	// ****************************************
	// bus cycles and comparison
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : step
	task automatic send(input logic r, input logic [7:0] code, input logic [15:0] d);
		i_cmd_valid = 1'b1;
		i_cmd_read = r;
		i_cmd_code = code;
		i_cmd_wdata = d;
		step(1);
		i_cmd_valid = 1'b0;
	endtask : send
	task automatic wr(input logic [7:0] code, input logic [15:0] d);
		send(1'b0, code, d);
		step(1);
	endtask : wr
	task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic [15:0] m);
		send(1'b1, code, 16'h0000);
		check({15'h0000, o_rd_valid}, 16'h0001);
		check(o_rd_data & m, exp);
		step(1);
	endtask : rd
	function automatic logic [31:0] flag_exp(input int k);
		// {word high byte, status byte, vout output_current_status status}
		case (k)
			0: return 32'h8001_1000;
			1: return 32'h8000_2000;
			2: return 32'h8000_4000;
			3: return 32'h8020_8000;
			4: return 32'h4000_0020;
			5: return 32'h4010_0080;
			6: return 32'h2008_0000;
			7, 8: return 32'h2000_0000;
			9: return 32'h2001_0000;
			10, 11: return 32'h0004_0000;
			12: return 32'h1000_0000;
			13: return 32'h1001_0000;
			default: return 32'h0002_0000;
		endcase
	endfunction : flag_exp
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		rd(CMD_UNIT_ON_OFF, 16'h0040, 16'hFFFF);
		rd(CMD_ENABLE_CFG, 16'h0006, 16'hFFFF);
		wr(CMD_VOUT_FORMAT, 16'h00FF);
		rd(CMD_VOUT_FORMAT, {8'h00, 3'h0, VOUT_EXPONENT}, 16'hFFFF);
		rd(CMD_STATUS_COMM, 16'h0080, 16'hFFFF);
		wr(CMD_CLEAR_FAULTS, 16'h0000);
		rd(8'h55, 16'h0000, 16'hFFFF);
		rd(CMD_STATUS_COMM, 16'h0080, 16'hFFFF);
		wr(CMD_CLEAR_FAULTS, 16'h0000);
		rd(CMD_VOUT_SETPOINT, 16'h0000, 16'hFFFF);
		// host keeps the mantissa at or below 3.6 V for this exponent
		wr(CMD_VOUT_SETPOINT, 16'h3999);
		check(o_vout_setpoint, 16'h3999);
		rd(CMD_VOUT_SETPOINT, 16'h3999, 16'hFFFF);
		act = 1'b0;
		pg = 1'b0;
		rd(CMD_STATUS_BYTE, 16'h0040, 16'hFFFF);
		rd(CMD_STATUS_WORD, 16'h0840, 16'hFFFF);
		act = 1'b1;
		pg = 1'b1;
	endtask : t_regs
	task automatic t_flags;
		logic [31:0] e;
		logic [7:0] m;
		for (int k = 0; k < 16; k++) begin
			e = flag_exp(k);
			// internal temperature does not light the temperature summary; bit 2 is masked anyway
			m = (k == 12 || k == 13) ? 8'hFB : 8'hFF;
			wr(CMD_CLEAR_FAULTS, 16'h0000);
			step(3);
			cond[k] = 1'b1;
			step(1);
			cond[k] = 1'b0;
			step(4);
			check({15'h0000, o_alert}, 16'h0001);
			rd(CMD_STATUS_BYTE, {8'h00, e[23:16]}, {8'h00, m});
			rd(CMD_STATUS_WORD, e[31:16], {8'hFF, m});
			rd(CMD_OUTPUT_VOLTAGE_STATUS, {8'h00, e[15:8]}, 16'hFFFF);
			rd(CMD_OUTPUT_CURRENT_STATUS, {8'h00, e[7:0]}, 16'hFFFF);
			if (k >= 6 && k <= 9) rd(CMD_STATUS_INPUT, 16'h0010 << (k - 6), 16'hFFFF);
			if (k == 10 || k == 11) rd(CMD_STATUS_TEMP, 16'h0040 << (k - 10), 16'hFFFF);
			if (k == 12 || k == 13) rd(CMD_STATUS_VENDOR, 16'h0040 << (k - 12), 16'hFFFF);
			if (k >= 14) rd(CMD_STATUS_COMM, (k == 14) ? 16'h0002 : 16'h0020, 16'hFFFF);
		end
		wr(CMD_CLEAR_FAULTS, 16'h0000);
		step(2);
		check({15'h0000, o_alert}, 16'h0000);
		rd(CMD_STATUS_WORD, 16'h0000, 16'hFFFF);
		// condition high only at the clearing edge itself: set must win
		cond[5] = 1'b1;
		send(1'b0, CMD_CLEAR_FAULTS, 16'h0000);
		cond[5] = 1'b0;
		step(1);
		rd(CMD_OUTPUT_CURRENT_STATUS, 16'h0080, 16'hFFFF);
		wr(CMD_CLEAR_FAULTS, 16'h0000);
	endtask : t_flags
	task automatic t_enable;
		logic [6:0] t;
		for (int i = 0; i < 12; i++) begin
			t = EN_TAB[(11 - i) * 7 +: 7];
			pin_want = t[1];
			wr(CMD_ENABLE_CFG, {12'h000, t[6:3]});
			wr(CMD_UNIT_ON_OFF, t[2] ? 16'h0080 : 16'h0040);
			for (int j = 0; j < 24 && o_unit_enable !== t[0]; j++) step(1);
			step(12);
			check({15'h0000, o_unit_enable}, {15'h0000, t[0]});
		end
		wr(CMD_ENABLE_CFG, 16'h0008);
		wr(CMD_UNIT_ON_OFF, 16'h0080);
		wr(CMD_CLEAR_FAULTS, 16'h0000);
		wr(CMD_UNIT_ON_OFF, 16'h00C0);
		step(3);
		check({15'h0000, o_unit_enable}, 16'h0001);
		// margining requested: refused, last mode kept
		wr(CMD_UNIT_ON_OFF, 16'h0090);
		rd(CMD_UNIT_ON_OFF, 16'h0080, 16'hFFFF);
		rd(CMD_STATUS_COMM, 16'h0080, 16'hFFFF);
		wr(CMD_UNIT_ON_OFF, 16'h007F);
		step(1);
		check({15'h0000, o_unit_enable}, 16'h0000);
	endtask : t_enable
	task automatic t_reset;
		i_reset = 1'b1;
		step(2);
		check({15'h0000, o_unit_enable}, 16'h0000);
		check(o_vout_setpoint, VSET_RESET);
		check({15'h0000, o_alert}, 16'h0000);
		i_reset = 1'b0;
		rd(CMD_STATUS_WORD, 16'h0000, 16'hFFFF);
		rd(CMD_UNIT_ON_OFF, {8'h00, OP_RESET}, 16'hFFFF);
		rd(CMD_ENABLE_CFG, {12'h000, CFG_RESET}, 16'hFFFF);
	endtask : t_reset
	// ****************************************
	// run control
	// ****************************************
	task automatic close_out;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			$display("[FAIL] %0t run did not finish", $time);
			close_out();
		end
	end
	initial begin
		step(12);
		i_reset = 1'b0;
		t_regs();
		t_flags();
		t_enable();
		t_reset();
		close_out();
	end
endmodule : testbench
